// >>> hw/sbmi_pkg.sv
// Shared constants and types for the system bus master interface.
// Assumes a system clock of 10 MHz and a bus clock from the link side.
package sbmi_pkg;

  // Address and data widths of the system bus
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;

  // Constant clock figure and the common source that feeds it
  localparam int CONST_CLK_KHZ = 9216;
  localparam int SRC_KHZ = 2 * CONST_CLK_KHZ;

  // Bus clock period and failsafe acknowledge time
  localparam int LINK_PERIOD_NS = 125;
  localparam int FAILSAFE_NS = 10000;
  localparam int FAILSAFE_CYC = (FAILSAFE_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
  localparam int TMR_W = 8;
  localparam logic [TMR_W-1:0] TMR_LAST = TMR_W'(FAILSAFE_CYC - 1);
  localparam logic [TMR_W-1:0] TMR_ZERO = 8'h00;
  localparam logic [TMR_W-1:0] TMR_ONE = 8'h01;

  // Idle levels of the active-low bus lines, then all-zero reset values
  localparam logic [ADDR_W-1:0] ADDR_IDLE = 16'hFFFF;
  localparam logic [DATA_W-1:0] DATA_IDLE = 8'hFF;
  localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 16'h0000;

  // Bus-side sequencer states, one-hot
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_CMD = 5'h02,
    ST_WAIT = 5'h04,
    ST_DONE = 5'h08,
    ST_HOLD = 5'h10
  } sbmi_state_e;

endpackage : sbmi_pkg

// >>> hw/sbmi_top.sv
// System bus master interface: processor request port on i_clk, bus side on the
// bus clock. Assumes the bus clock is the common source of the constant clock and
// that responders and bus-priority logic run on that same bus clock.
// Function
// - Early acknowledge ends the cycle without waiting.
// - Constant clock output for expansion boards.
// - Constant and bus clocks share one source.
// - Sixteen active-low address lines, top is MSB.
// - Eight active-low bidirectional data lines, top MSB.
// - Accept active-low external interrupt request.
// - Bus priority in, bus-in-use answers, then DMA.
// - Processor held while bus not owned.
// - Failsafe acknowledge for interrupt and missing devices.
// - Bus-in-use driven from hold acknowledge.

// Three-stage synchroniser; output follows once stages two and three agree
module sbmi_sync3 (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_async,
  output logic o_level
);
  logic [2:0] stage_q;

  // Capture chain; the level follows once stages two and three agree
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      stage_q <= 3'h0;
      o_level <= 1'b0;
    end
    else
    begin
      stage_q <= {stage_q[1:0], i_async};
      if (stage_q[1] == stage_q[2])
        o_level <= stage_q[2];
    end
  end
endmodule : sbmi_sync3

module sbmi_top (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_bus_clk,
  // Processor side
  input wire logic i_req,
  input wire logic i_write,
  input wire logic i_io,
  input wire logic i_inta,
  input wire logic [sbmi_pkg::ADDR_W-1:0] i_addr,
  input wire logic [sbmi_pkg::DATA_W-1:0] i_wdata,
  output logic o_ready,
  output logic o_done,
  output logic [sbmi_pkg::DATA_W-1:0] o_rdata,
  output logic o_hold,
  output logic o_irq,
  input wire logic i_external_irq_n,
  // Bus side
  output logic [sbmi_pkg::ADDR_W-1:0] o_bus_address_lines_n,
  output logic o_bus_drive_oe,
  input wire logic [sbmi_pkg::DATA_W-1:0] i_bus_data_lines_n,
  output logic [sbmi_pkg::DATA_W-1:0] o_bus_data_lines_n,
  output logic o_bus_data_oe,
  output logic o_mem_read_n,
  output logic o_mem_write_n,
  output logic o_io_read_n,
  output logic o_io_write_n,
  input wire logic i_transfer_done_ack_n,
  input wire logic i_early_ack_n,
  input wire logic i_bus_priority_in,
  output logic o_bus_in_use_n,
  output logic o_constant_clock_out_n,
  output logic o_bus_clock_n
);
  // Processor-domain request holding registers
  logic busy_q, req_tgl_q, seen_q, wr_q, io_q, inta_q;
  logic [sbmi_pkg::ADDR_W-1:0] addr_q;
  logic [sbmi_pkg::DATA_W-1:0] wdata_q;
  logic done_lvl, hold_lvl, irq_lvl;
  wire take_req = i_req && !busy_q;
  wire done_evt = (done_lvl != seen_q);

  // Bus-domain state
  logic rst_meta_q;
  logic rst_link_q;
  sbmi_pkg::sbmi_state_e state_q;
  logic done_tgl_q;
  logic hold_ack_q;
  logic [sbmi_pkg::TMR_W-1:0] tmr_q;
  logic [sbmi_pkg::DATA_W-1:0] rdata_q;
  logic req_lvl;
  wire pending = (req_lvl != done_tgl_q);
  wire any_ack = !i_transfer_done_ack_n || !i_early_ack_n;
  wire tmr_end = (tmr_q == sbmi_pkg::TMR_LAST);
  wire cmd_mrd = !io_q && !wr_q;
  wire cmd_mwr = !io_q && wr_q;
  wire cmd_ird = io_q && !wr_q;
  wire cmd_iwr = io_q && wr_q;
  wire start_cyc = (state_q == sbmi_pkg::ST_IDLE) && !i_bus_priority_in && pending;

  // Crossings: request and completion toggles, hold level, interrupt pin
  sbmi_sync3 u_req_sync (.i_clk(i_bus_clk), .i_reset(rst_link_q), .i_async(req_tgl_q),
    .o_level(req_lvl));
  sbmi_sync3 u_done_sync (.i_clk(i_clk), .i_reset(i_reset), .i_async(done_tgl_q),
    .o_level(done_lvl));
  sbmi_sync3 u_hold_sync (.i_clk(i_clk), .i_reset(i_reset), .i_async(hold_ack_q),
    .o_level(hold_lvl));
  sbmi_sync3 u_irq_sync (.i_clk(i_clk), .i_reset(i_reset), .i_async(!i_external_irq_n),
    .o_level(irq_lvl));

  // Processor side: take one request, hold it stable until completion returns
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      {busy_q, req_tgl_q, seen_q, wr_q, io_q, inta_q} <= 6'h00;
      addr_q <= sbmi_pkg::ADDR_ZERO;
      wdata_q <= sbmi_pkg::DATA_ZERO;
      {o_ready, o_done, o_hold, o_irq} <= 4'h0;
      o_rdata <= sbmi_pkg::DATA_ZERO;
    end
    else
    begin
      o_done <= done_evt;
      o_hold <= hold_lvl;
      o_irq <= irq_lvl;
      o_ready <= !busy_q && !take_req && !done_evt;
      if (take_req)
      begin
        busy_q <= 1'b1;
        req_tgl_q <= !req_tgl_q;
        wr_q <= i_write;
        io_q <= i_io;
        inta_q <= i_inta;
        addr_q <= i_addr;
        wdata_q <= i_wdata;
      end
      else if (done_evt)
      begin
        busy_q <= 1'b0;
        seen_q <= done_lvl;
        o_rdata <= rdata_q;
      end
    end
  end

  // Bus-domain reset: asserted at once, released on the bus clock
  always_ff @(posedge i_bus_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      rst_meta_q <= 1'b1;
      rst_link_q <= 1'b1;
    end
    else
    begin
      rst_meta_q <= 1'b0;
      rst_link_q <= rst_meta_q;
    end
  end

  // Bus sequencer, plus both clock outputs toggled from the one bus clock source
  always_ff @(posedge i_bus_clk or posedge rst_link_q)
  begin
    if (rst_link_q)
    begin
      o_constant_clock_out_n <= 1'b1;
      o_bus_clock_n <= 1'b1;
      state_q <= sbmi_pkg::ST_IDLE;
      done_tgl_q <= 1'b0;
      hold_ack_q <= 1'b0;
      tmr_q <= sbmi_pkg::TMR_ZERO;
      rdata_q <= sbmi_pkg::DATA_ZERO;
      o_bus_address_lines_n <= sbmi_pkg::ADDR_IDLE;
      o_bus_drive_oe <= 1'b0;
      o_bus_data_lines_n <= sbmi_pkg::DATA_IDLE;
      o_bus_data_oe <= 1'b0;
      {o_mem_read_n, o_mem_write_n, o_io_read_n, o_io_write_n} <= 4'hF;
      o_bus_in_use_n <= 1'b1;
    end
    else
    begin
      o_constant_clock_out_n <= !o_constant_clock_out_n;
      o_bus_clock_n <= !o_constant_clock_out_n;
      case (state_q)
        sbmi_pkg::ST_IDLE:
        begin
          if (i_bus_priority_in)
          begin
            state_q <= sbmi_pkg::ST_HOLD;
            hold_ack_q <= 1'b1;
            o_bus_in_use_n <= 1'b0;
          end
          else if (pending && inta_q)
            state_q <= sbmi_pkg::ST_DONE;
          else if (pending)
          begin
            state_q <= sbmi_pkg::ST_CMD;
            o_bus_address_lines_n <= ~addr_q;
            o_bus_drive_oe <= 1'b1;
            o_bus_data_lines_n <= ~wdata_q;
            o_bus_data_oe <= wr_q;
          end
        end
        sbmi_pkg::ST_CMD:
        begin
          state_q <= sbmi_pkg::ST_WAIT;
          tmr_q <= sbmi_pkg::TMR_ZERO;
          o_mem_read_n <= !cmd_mrd;
          o_mem_write_n <= !cmd_mwr;
          o_io_read_n <= !cmd_ird;
          o_io_write_n <= !cmd_iwr;
        end
        sbmi_pkg::ST_WAIT:
        begin
          tmr_q <= tmr_q + sbmi_pkg::TMR_ONE;
          if (any_ack || tmr_end)
            state_q <= sbmi_pkg::ST_DONE;
        end
        sbmi_pkg::ST_DONE:
        begin
          state_q <= sbmi_pkg::ST_IDLE;
          done_tgl_q <= !done_tgl_q;
          if (!wr_q && !inta_q)
            rdata_q <= ~i_bus_data_lines_n;
          o_bus_address_lines_n <= sbmi_pkg::ADDR_IDLE;
          o_bus_drive_oe <= 1'b0;
          o_bus_data_lines_n <= sbmi_pkg::DATA_IDLE;
          o_bus_data_oe <= 1'b0;
          {o_mem_read_n, o_mem_write_n, o_io_read_n, o_io_write_n} <= 4'hF;
        end
        sbmi_pkg::ST_HOLD:
        begin
          if (!i_bus_priority_in)
          begin
            state_q <= sbmi_pkg::ST_IDLE;
            hold_ack_q <= 1'b0;
            o_bus_in_use_n <= 1'b1;
          end
        end
        default:
          state_q <= sbmi_pkg::ST_IDLE;
      endcase
    end
  end

  // Bus-side checks
  wait_states_a: assert property (@(posedge i_bus_clk) disable iff (rst_link_q)
    (state_q == sbmi_pkg::ST_WAIT) && !any_ack && !tmr_end |=> (state_q == sbmi_pkg::ST_WAIT)
      && !(o_mem_read_n && o_mem_write_n && o_io_read_n && o_io_write_n))
    else $error("cycle left wait without acknowledge");
  early_ack_a: assert property (@(posedge i_bus_clk) disable iff (rst_link_q)
    (state_q == sbmi_pkg::ST_WAIT) && !i_early_ack_n |=> (state_q == sbmi_pkg::ST_DONE)
      ##1 (o_mem_read_n && o_mem_write_n))
    else $error("early acknowledge did not end cycle");
  failsafe_end_a: assert property (@(posedge i_bus_clk) disable iff (rst_link_q)
    (state_q == sbmi_pkg::ST_CMD) ##1 (!any_ack)[*8] |-> (state_q == sbmi_pkg::ST_WAIT))
    else $error("failsafe fired too early");
  inta_failsafe_a: assert property (@(posedge i_bus_clk) disable iff (rst_link_q)
    start_cyc && inta_q |=> (state_q == sbmi_pkg::ST_DONE) && o_mem_read_n && o_io_read_n
      ##1 (done_tgl_q != $past(done_tgl_q)))
    else $error("interrupt cycle not acknowledged locally");
  grant_bus_a: assert property (@(posedge i_bus_clk) disable iff (rst_link_q)
    (state_q == sbmi_pkg::ST_IDLE) && i_bus_priority_in |=> !o_bus_in_use_n && !o_bus_drive_oe
      && !o_bus_data_oe)
    else $error("bus not released on priority request");
  in_use_hold_a: assert property (@(posedge i_bus_clk) disable iff (rst_link_q)
    hold_ack_q |-> !o_bus_in_use_n && (state_q == sbmi_pkg::ST_HOLD) && o_mem_write_n)
    else $error("bus-in-use not following hold acknowledge");
  regain_bus_a: assert property (@(posedge i_bus_clk) disable iff (rst_link_q)
    (state_q == sbmi_pkg::ST_HOLD) && !i_bus_priority_in |=> o_bus_in_use_n && !hold_ack_q)
    else $error("bus not regained after priority drop");
  addr_data_a: assert property (@(posedge i_bus_clk) disable iff (rst_link_q)
    start_cyc && !inta_q |=> (o_bus_address_lines_n == ~addr_q) && o_bus_drive_oe
      && (o_bus_data_oe == wr_q) && (!wr_q || (o_bus_data_lines_n == ~wdata_q)))
    else $error("address or data not driven inverted");
  clock_pair_a: assert property (@(posedge i_bus_clk) disable iff (rst_link_q)
    ##1 (o_bus_clock_n == o_constant_clock_out_n) |=>
      (o_constant_clock_out_n != $past(o_constant_clock_out_n)))
    else $error("clock outputs not from common toggle");

  // Processor-side checks
  hold_track_a: assert property (@(posedge i_clk) disable iff (i_reset)
    hold_lvl |=> o_hold)
    else $error("processor not held while bus given away");
  irq_track_a: assert property (@(posedge i_clk) disable iff (i_reset)
    $rose(irq_lvl) |=> o_irq)
    else $error("interrupt request not passed on");

endmodule : sbmi_top

// >>> verif/sbmi_bus_model.sv
// Memory and I/O responder standing on the far side of the bus.
// Assumes commands and address are registered on the same bus clock.
module sbmi_bus_model (
  input wire logic i_bus_clk,
  input wire logic [15:0] i_addr_n,
  input wire logic [7:0] i_data_n,
  input wire logic i_rd_n,
  input wire logic i_wr_n,
  input wire logic [3:0] i_delay,
  input wire logic i_early,
  input wire logic i_mute,
  output logic [7:0] o_data_n = 8'h00,
  output logic o_transfer_done_ack_n = 1'b1,
  output logic o_early_ack_n = 1'b1
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] mem [0:255];
  logic [3:0] cnt_q = 4'h0;
  wire act = !i_rd_n || !i_wr_n;
  wire [7:0] idx = ~i_addr_n[7:0];
  wire due = act && (cnt_q >= i_delay);
  // Count command time, move data, then acknowledge; released lines toggle
  always @(posedge i_bus_clk)
  begin
    cnt_q <= act ? cnt_q + 4'h1 : 4'h0;
    o_data_n <= (due && !i_rd_n) ? ~mem[idx] : ~o_data_n;
    if (due && !i_wr_n)
      mem[idx] <= ~i_data_n;
    o_transfer_done_ack_n <= !(act && cnt_q > i_delay && !i_mute);
    o_early_ack_n <= !(due && i_early && !i_mute);
  end
endmodule : sbmi_bus_model

// >>> verif/tb_system_bus_master_interface.sv
// Self-checking bench for the system bus master interface.
// Assumes the responder model and a bus-side DMA request driven here.
module tb_system_bus_master_interface;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0, bclk = 1'b0, rst = 1'b1, req = 1'b0, wr = 1'b0, io = 1'b0;
  logic inta = 1'b0, irq_n = 1'b1, prio = 1'b0, early = 1'b0, mute = 1'b0;
  logic [15:0] addr = 16'h0000, addr_n, seen_a;
  logic [7:0] wdata = 8'h00, rdata, dout_n, mdl_n;
  logic [3:0] delay = 4'h0, seen_c;
  logic ready, done, hold, irq, drv_oe, data_oe, mrd_n, mwr_n, iord_n, iowr_n;
  logic done_ack_n, early_ack_n, busy_n, const_clk_n, bclk_n;
  int n_errors = 0, num_checks = 0, slen = 0, cyc = 0;
  wire [7:0] data_n = data_oe ? dout_n : mdl_n;

  // Clocks of both domains
  always #50 clk = ~clk;
  always #62.5 bclk = ~bclk;

  sbmi_top dut (.i_clk(clk), .i_reset(rst), .i_bus_clk(bclk), .i_req(req), .i_write(wr),
    .i_io(io), .i_inta(inta), .i_addr(addr), .i_wdata(wdata), .o_ready(ready), .o_done(done),
    .o_rdata(rdata), .o_hold(hold), .o_irq(irq), .i_external_irq_n(irq_n),
    .o_bus_address_lines_n(addr_n), .o_bus_drive_oe(drv_oe), .i_bus_data_lines_n(data_n),
    .o_bus_data_lines_n(dout_n), .o_bus_data_oe(data_oe), .o_mem_read_n(mrd_n),
    .o_mem_write_n(mwr_n), .o_io_read_n(iord_n), .o_io_write_n(iowr_n),
    .i_transfer_done_ack_n(done_ack_n), .i_early_ack_n(early_ack_n), .i_bus_priority_in(prio),
    .o_bus_in_use_n(busy_n), .o_constant_clock_out_n(const_clk_n), .o_bus_clock_n(bclk_n));

  sbmi_bus_model mdl (.i_bus_clk(bclk), .i_addr_n(addr_n), .i_data_n(data_n),
    .i_rd_n(mrd_n & iord_n), .i_wr_n(mwr_n & iowr_n), .i_delay(delay), .i_early(early),
    .i_mute(mute), .o_data_n(mdl_n), .o_transfer_done_ack_n(done_ack_n),
    .o_early_ack_n(early_ack_n));

  // Bus monitor: address, command and strobe length
  always @(posedge bclk)
    if ({mrd_n, mwr_n, iord_n, iowr_n} != 4'hF)
    begin
      seen_a <= ~addr_n;
      seen_c <= ~{mrd_n, mwr_n, iord_n, iowr_n};
      slen <= slen + 1;
    end

  // Hang guard
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_errors++;
      wrap_up;
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wrap_up;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : wrap_up

  // One processor cycle, waiting for ready and then for done
  task automatic op(input logic w, input logic i, input logic ia, input logic [15:0] a,
      input logic [7:0] d, output logic [7:0] q);
    int k;
    k = 0;
    do
    begin
      @(posedge clk);
      #1;
      k++;
    end
    while (ready !== 1'b1 && k < 50);
    check({15'h0, ready}, 16'h1);
    slen = 0;
    seen_c = 4'h0;
    @(posedge clk);
    req <= 1'b1;
    wr <= w;
    io <= i;
    inta <= ia;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    req <= 1'b0;
    inta <= 1'b0;
    k = 0;
    do
    begin
      @(posedge clk);
      #1;
      k++;
    end
    while (done !== 1'b1 && k < 600);
    check({15'h0, done}, 16'h1);
    q = rdata;
  endtask : op

  task automatic t_rw;
    logic [7:0] q;
    logic [15:0] a;
    logic [7:0] d;
    delay <= 4'h5;
    for (int i = 0; i < 2; i++)
    begin
      a = i ? 16'h0081 : 16'hC35A;
      d = i ? 8'h96 : 8'h3C;
      op(1'b1, i[0], 1'b0, a, d, q);
      check(seen_a, a);
      check({12'h0, seen_c}, i ? 16'h1 : 16'h4);
      check({15'h0, slen > 6}, 16'h1);
      op(1'b0, i[0], 1'b0, a, 8'h00, q);
      check({8'h00, q}, {8'h00, d});
      check({12'h0, seen_c}, i ? 16'h2 : 16'h8);
    end
    $display("t_rw complete");
  endtask : t_rw

  task automatic t_early;
    logic [7:0] q;
    delay <= 4'h3;
    early <= 1'b1;
    op(1'b1, 1'b0, 1'b0, 16'h1234, 8'hE7, q);
    op(1'b0, 1'b0, 1'b0, 16'h1234, 8'h00, q);
    check({8'h00, q}, 16'h00E7);
    check(slen[15:0], 16'h0006);
    early <= 1'b0;
    $display("t_early complete");
  endtask : t_early

  task automatic t_dma;
    int k;
    int n;
    @(posedge bclk);
    prio <= 1'b1;
    repeat (3) @(posedge bclk);
    #1;
    check({14'h0, busy_n, drv_oe}, 16'h0);
    check({15'h0, data_oe}, 16'h0);
    repeat (8) @(posedge clk);
    #1;
    check({15'h0, hold}, 16'h1);
    // A read asked for while the bus is away must wait for its return
    seen_c = 4'h0;
    @(posedge clk);
    req <= 1'b1;
    addr <= 16'h1234;
    wr <= 1'b0;
    io <= 1'b0;
    @(posedge clk);
    req <= 1'b0;
    n = 0;
    repeat (40)
    begin
      @(posedge clk);
      #1;
      if (done !== 1'b0)
        n++;
    end
    check({12'h0, seen_c}, 16'h0);
    check(n[15:0], 16'h0);
    @(posedge bclk);
    prio <= 1'b0;
    repeat (3) @(posedge bclk);
    #1;
    check({15'h0, busy_n}, 16'h1);
    repeat (8) @(posedge clk);
    #1;
    check({15'h0, hold}, 16'h0);
    k = 0;
    while (done !== 1'b1 && k < 600)
    begin
      @(posedge clk);
      #1;
      k++;
    end
    check({15'h0, done}, 16'h1);
    check({8'h00, rdata}, 16'h00E7);
    $display("t_dma complete");
  endtask : t_dma

  task automatic t_fail;
    logic [7:0] q;
    mute <= 1'b1;
    op(1'b0, 1'b0, 1'b0, 16'h7777, 8'h00, q);
    mute <= 1'b0;
    op(1'b0, 1'b0, 1'b1, 16'h0000, 8'h00, q);
    check({12'h0, seen_c}, 16'h0);
    $display("t_fail complete");
  endtask : t_fail

  task automatic t_irq;
    @(posedge clk);
    irq_n <= 1'b0;
    repeat (6) @(posedge clk);
    #1;
    check({15'h0, irq}, 16'h1);
    @(posedge clk);
    irq_n <= 1'b1;
    repeat (6) @(posedge clk);
    #1;
    check({15'h0, irq}, 16'h0);
    $display("t_irq complete");
  endtask : t_irq

  task automatic t_clk;
    logic pc, pb;
    int nc, nb;
    nc = 0;
    nb = 0;
    @(posedge bclk);
    #1;
    pc = const_clk_n;
    pb = bclk_n;
    repeat (40)
    begin
      @(posedge bclk);
      #1;
      nc += (const_clk_n !== pc);
      nb += (bclk_n !== pb);
      pc = const_clk_n;
      pb = bclk_n;
    end
    check(nc[15:0], 16'h0028);
    check(nb[15:0], 16'h0028);
    $display("t_clk complete");
  endtask : t_clk

  // Main sequence
  initial
  begin
    repeat (12) @(posedge clk);
    #1;
    check({addr_n[15:0]}, 16'hFFFF);
    @(posedge clk);
    rst <= 1'b0;
    t_rw;
    t_early;
    t_dma;
    t_fail;
    t_irq;
    t_clk;
    wrap_up;
  end
endmodule : tb_system_bus_master_interface
